// ### inc/acr_defs.svh
// register offsets, field positions, reset values and codes of the block
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_ADDR_W        8
`define ACR_OFF_CLK       8'h7c
`define ACR_OFF_SEL       8'h80
`define ACR_OFF_REF       8'h84
`define ACR_OFF_CORE      8'h88
`define ACR_RST_CLK       32'h00000101
`define ACR_RST_SEL       32'h00000000
`define ACR_RST_REF       32'h00000000
`define ACR_RST_CORE      32'h00010106
`define ACR_WMASK_CLK     32'h0000ffff
`define ACR_WMASK_SEL     32'h00ffffff
`define ACR_WMASK_REF     32'h3fffffff
`define ACR_WMASK_CORE    32'h0001ff8f
`define ACR_F_CLK_HIGH    15:8
`define ACR_F_CLK_LOW     7:0
`define ACR_F_REF_STAT    31:30
`define ACR_F_REF_LOW     29:0
`define ACR_B_PAD_DRIVE   29
`define ACR_F_SW_DLY      28:16
`define ACR_F_CHG_DLY     15:0
`define ACR_F_WARM_DLY    16:7
`define ACR_B_SHIFT       3
`define ACR_F_RES         2:1
`define ACR_B_DIFF        0
`define ACR_F_RAW_TOP10   11:2
`define ACR_RES_10        2'h2
`define ACR_RES_12        2'h3
`define ACR_SRC_PAD       2'h0
`define ACR_SRC_GPIO      2'h1
`define ACR_RESP_OK       2'h0
`define ACR_RESP_ERR      2'h2
`endif

// ### inc/acr_pkg.sv
// types shared by the converter clock and reference configuration block
package acr_pkg;
  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_CHARGE = 5'h02,
    ST_WARM   = 5'h04,
    ST_READY  = 5'h08,
    ST_SWITCH = 5'h10
  } acr_st_e;

  typedef struct packed {
    logic [1:0] resolution_select;
    logic       differential_input_mode;
  } acr_core_cfg_s;

  typedef struct packed {
    logic [31:0] r_clk;
    logic [31:0] r_sel;
    logic [31:0] r_ref;
    logic [31:0] r_core;
    logic [7:0]  div_cnt;
    logic        adc_clk;
    acr_st_e     st;
    logic [15:0] cnt;
    logic [1:0]  ref_stat;
    logic        pad_low_ded;
    logic        pad_low_gpio;
    logic        conv_ready;
    logic [31:0] result;
    logic        result_vld;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } acr_state_s;
endpackage

// ### src/acr_top.sv
// converter clock, reference select and core configuration registers
`timescale 1ns/1ps
`include "acr_defs.svh"

// How it works
// - high count bits 15:8, zero not valid
// - low count bits 7:0, resets to one
// - two-bit reference select per channel, twelve
// - status bits 31:30 show reference in effect
// - pad bit drives unused reference pad low
// - thirteen-bit switch delay, resets to zero
// - sixteen-bit charge delay, resets to zero
// - warm-up in converter clocks, reset 202h
// - right-justify bit shifts result by resolution
// - resolution code 10b ten, 11b twelve bits
// - input mode bit: single-ended or differential
// - result upper bits above resolution read zero
module acr_top #(
  parameter int NUM_CH = 12
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  conv_enable,
  input  wire logic [3:0]            conv_channel,
  input  wire logic [11:0]           raw_data,
  input  wire logic                  raw_valid,
  output      logic                  adc_clk,
  output      logic                  conv_ready,
  output      logic [1:0]            ref_source,
  output      logic                  pad_low_dedicated,
  output      logic                  pad_low_gpio,
  output      acr_pkg::acr_core_cfg_s core_cfg,
  output      logic [31:0]           result,
  output      logic                  result_valid
);

  localparam acr_pkg::acr_state_s RST = '{
    r_clk:   `ACR_RST_CLK,
    r_sel:   `ACR_RST_SEL,
    r_ref:   `ACR_RST_REF,
    r_core:  `ACR_RST_CORE,
    st:      acr_pkg::ST_OFF,
    default: '0
  };

  acr_pkg::acr_state_s s_q;
  acr_pkg::acr_state_s s_d;

  logic [7:0]  hi_len;
  logic [7:0]  lo_len;
  logic [7:0]  phase_len;
  logic        phase_end;
  logic        adc_rise;
  logic [1:0]  sel_act;
  logic        wr_en;
  logic [7:0]  rd_addr;
  logic [7:0]  wr_addr;
  logic [31:0] rd_word;
  logic        rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return (v & mask) | (old & ~mask);
  endfunction

  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign wr_addr = {s_q.aw_addr[7:2], 2'b00};

  // zero is not a valid count, run it as one
  assign hi_len = (s_q.r_clk[`ACR_F_CLK_HIGH] == 8'h00) ? 8'h01
                : s_q.r_clk[`ACR_F_CLK_HIGH];
  // same guard on the low count
  assign lo_len = (s_q.r_clk[`ACR_F_CLK_LOW] == 8'h00) ? 8'h01
                : s_q.r_clk[`ACR_F_CLK_LOW];
  assign phase_len = s_q.adc_clk ? hi_len : lo_len;
  assign phase_end = ({1'b0, s_q.div_cnt} + 9'h001) >= {1'b0, phase_len};
  assign adc_rise  = !s_q.adc_clk && phase_end;

  // channels beyond the table fall back to the pad
  always_comb begin
    sel_act = `ACR_SRC_PAD;
    if (int'(conv_channel) < NUM_CH) begin
      sel_act = s_q.r_sel[{conv_channel, 1'b0} +: 2];
    end
  end

  // status field reads the source in effect now
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (rd_addr)
      `ACR_OFF_CLK:  rd_word = s_q.r_clk;
      `ACR_OFF_SEL:  rd_word = s_q.r_sel;
      `ACR_OFF_REF:  rd_word = {s_q.ref_stat, s_q.r_ref[`ACR_F_REF_LOW]};
      `ACR_OFF_CORE: rd_word = s_q.r_core;
      default:       rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    s_d   = s_q;
    wr_en = s_q.aw_have && s_q.w_have && !s_q.bvalid;

    // write channels are taken independently, in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_en) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `ACR_RESP_OK;
      case (wr_addr)
        `ACR_OFF_CLK:  s_d.r_clk  = merge(s_q.r_clk, s_q.w_data,
                                          s_q.w_strb, `ACR_WMASK_CLK);
        `ACR_OFF_SEL:  s_d.r_sel  = merge(s_q.r_sel, s_q.w_data,
                                          s_q.w_strb, `ACR_WMASK_SEL);
        // status bits are read-only, the mask keeps them out
        `ACR_OFF_REF:  s_d.r_ref  = merge(s_q.r_ref, s_q.w_data,
                                          s_q.w_strb, `ACR_WMASK_REF);
        `ACR_OFF_CORE: s_d.r_core = merge(s_q.r_core, s_q.w_data,
                                          s_q.w_strb, `ACR_WMASK_CORE);
        default:       s_d.bresp  = `ACR_RESP_ERR;
      endcase
    end
    s_d.awready = !s_d.aw_have;
    s_d.wready  = !s_d.w_have;

    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_hit ? `ACR_RESP_OK : `ACR_RESP_ERR;
    end
    s_d.arready = !s_d.rvalid;

    // free-running divider from the system clock
    if (phase_end) begin
      s_d.div_cnt = 8'h00;
      s_d.adc_clk = !s_q.adc_clk;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 8'h01;
    end

    case (s_q.st)
      acr_pkg::ST_OFF: begin
        if (conv_enable) begin
          s_d.st       = acr_pkg::ST_CHARGE;
          s_d.cnt      = s_q.r_ref[`ACR_F_CHG_DLY];
          s_d.ref_stat = sel_act;
        end
      end
      // charge delay counted in system clocks
      acr_pkg::ST_CHARGE: begin
        if (s_q.cnt == 16'h0000) begin
          s_d.st  = acr_pkg::ST_WARM;
          s_d.cnt = {6'h00, s_q.r_core[`ACR_F_WARM_DLY]};
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      // warm-up counted in converter clock rising edges
      acr_pkg::ST_WARM: begin
        if (s_q.cnt == 16'h0000) begin
          s_d.st = acr_pkg::ST_READY;
        end else if (adc_rise) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      acr_pkg::ST_READY: begin
        if (sel_act != s_q.ref_stat) begin
          s_d.st  = acr_pkg::ST_SWITCH;
          s_d.cnt = {3'h0, s_q.r_ref[`ACR_F_SW_DLY]};
        end
      end
      // switch delay before the new source takes effect
      acr_pkg::ST_SWITCH: begin
        if (s_q.cnt == 16'h0000) begin
          s_d.st       = acr_pkg::ST_READY;
          s_d.ref_stat = sel_act;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      default: s_d.st = acr_pkg::ST_OFF;
    endcase
    if (!conv_enable) begin
      s_d.st = acr_pkg::ST_OFF;
    end
    // conversion waits out charge, warm-up and any switch
    s_d.conv_ready = (s_d.st == acr_pkg::ST_READY);

    // only the pad not in use is pulled low
    s_d.pad_low_ded  = s_q.r_ref[`ACR_B_PAD_DRIVE]
                     && (s_d.ref_stat == `ACR_SRC_GPIO);
    s_d.pad_low_gpio = s_q.r_ref[`ACR_B_PAD_DRIVE]
                     && (s_d.ref_stat != `ACR_SRC_GPIO);

    // justify by resolution; reserved codes run as twelve
    s_d.result_vld = raw_valid;
    if (raw_valid) begin
      // ten-bit code keeps the top ten raw bits
      if (s_q.r_core[`ACR_F_RES] == `ACR_RES_10) begin
        // bits above the resolution stay zero
        s_d.result = s_q.r_core[`ACR_B_SHIFT]
                   ? {22'h000000, raw_data[`ACR_F_RAW_TOP10]}
                   : {20'h00000, raw_data[`ACR_F_RAW_TOP10], 2'b00};
      end else begin
        s_d.result = {20'h00000, raw_data};
      end
    end
  end

  // every field returns to its default on reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready     = s_q.awready;
  assign s_axi_wready      = s_q.wready;
  assign s_axi_bresp       = s_q.bresp;
  assign s_axi_bvalid      = s_q.bvalid;
  assign s_axi_arready     = s_q.arready;
  assign s_axi_rdata       = s_q.rdata;
  assign s_axi_rresp       = s_q.rresp;
  assign s_axi_rvalid      = s_q.rvalid;
  assign adc_clk           = s_q.adc_clk;
  assign conv_ready        = s_q.conv_ready;
  assign ref_source        = s_q.ref_stat;
  assign pad_low_dedicated = s_q.pad_low_ded;
  assign pad_low_gpio      = s_q.pad_low_gpio;
  // mode and resolution reach the core straight from flops
  assign core_cfg.resolution_select       = s_q.r_core[`ACR_F_RES];
  assign core_cfg.differential_input_mode = s_q.r_core[`ACR_B_DIFF];
  assign result            = s_q.result;
  assign result_valid      = s_q.result_vld;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_high_phase;
    s_q.adc_clk && phase_end |=> !s_q.adc_clk && s_q.div_cnt == 8'h00;
  endproperty
  a_high_phase: assert property (p_high_phase)
    else $error("converter clock high phase length wrong");

  property p_low_phase;
    !s_q.adc_clk && !phase_end |=> !s_q.adc_clk
      && s_q.div_cnt == $past(s_q.div_cnt) + 8'h01;
  endproperty
  a_low_phase: assert property (p_low_phase)
    else $error("converter clock left low phase early");

  property p_reset_defaults;
    $rose(rstn) |-> s_q.r_clk[`ACR_F_CLK_LOW] == 8'h01
      && s_q.r_core == `ACR_RST_CORE && s_q.r_ref == `ACR_RST_REF;
  endproperty
  a_reset_defaults: assert property (@(posedge clk) disable iff (1'b0)
    p_reset_defaults)
    else $error("configuration not at default after reset");

  property p_switch_apply;
    s_q.st == acr_pkg::ST_SWITCH && s_q.cnt == 16'h0000 && conv_enable
      |=> ref_source == $past(sel_act) && conv_ready;
  endproperty
  a_switch_apply: assert property (p_switch_apply)
    else $error("reference status did not follow the selection");

  property p_pad_low;
    ##1 pad_low_gpio == ($past(s_q.r_ref[`ACR_B_PAD_DRIVE])
      && ref_source != `ACR_SRC_GPIO);
  endproperty
  a_pad_low: assert property (p_pad_low)
    else $error("unused reference pad drive wrong");

  sequence s_charge_end;
    s_q.st == acr_pkg::ST_CHARGE && s_q.cnt == 16'h0000 && conv_enable;
  endsequence
  sequence s_warm_end;
    s_q.st == acr_pkg::ST_WARM && s_q.cnt == 16'h0000 && conv_enable;
  endsequence

  property p_warm_entry;
    s_charge_end |=> s_q.st == acr_pkg::ST_WARM
      && s_q.cnt == {6'h00, s_q.r_core[`ACR_F_WARM_DLY]} && !conv_ready;
  endproperty
  a_warm_entry: assert property (p_warm_entry)
    else $error("warm-up not loaded after charge");

  property p_warm_done;
    s_warm_end |=> conv_ready;
  endproperty
  a_warm_done: assert property (p_warm_done)
    else $error("ready not raised after warm-up");

  property p_ten_bit;
    raw_valid && core_cfg.resolution_select == `ACR_RES_10
      && !s_q.r_core[`ACR_B_SHIFT]
      |=> result_valid && result[1:0] == 2'b00
      && result[31:12] == 20'h00000;
  endproperty
  a_ten_bit: assert property (p_ten_bit)
    else $error("unshifted ten-bit result misplaced");

  property p_twelve_bit;
    raw_valid && core_cfg.resolution_select == `ACR_RES_12
      |=> result == {20'h00000, $past(raw_data)};
  endproperty
  a_twelve_bit: assert property (p_twelve_bit)
    else $error("twelve-bit result wrong");

  property p_mode_write;
    wr_en && wr_addr == `ACR_OFF_CORE && s_q.w_strb[0]
      |=> core_cfg.differential_input_mode == $past(s_q.w_data[0])
      && s_axi_bvalid;
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("input mode bit not written");

  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before bready");

endmodule

// ### tb/acr_core_model.sv
// stand-in for the converter sequencer and analog core inputs
`timescale 1ns/1ps
module acr_core_model (
  input  wire logic        clk,
  output      logic        conv_enable,
  output      logic [3:0]  conv_channel,
  output      logic [11:0] raw_data,
  output      logic        raw_valid
);
  initial begin
    conv_enable = 1'b0;
    conv_channel = 4'h0;
    raw_data = 12'h000;
    raw_valid = 1'b0;
  end
  task automatic power(input logic en, input logic [3:0] ch);
    @(posedge clk);
    conv_enable <= en;
    conv_channel <= ch;
  endtask
  // data is only good in its strobe cycle, so it turns to junk after
  task automatic sample(input logic [11:0] d);
    @(posedge clk);
    raw_data <= d;
    raw_valid <= 1'b1;
    @(posedge clk);
    raw_data <= ~d;
    raw_valid <= 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the converter clock and reference block
`timescale 1ns/1ps
`include "acr_defs.svh"
module tb;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, result, d;
  logic [3:0]  wstrb, conv_channel;
  logic [1:0]  bresp, rresp, ref_source, r;
  logic        conv_enable, raw_valid, adc_clk, conv_ready, result_valid;
  logic        pad_low_dedicated, pad_low_gpio;
  logic [11:0] raw_data;
  acr_pkg::acr_core_cfg_s core_cfg;
  int          error_cnt, total_checks, n;
  logic [7:0]  offs[4] = '{`ACR_OFF_CLK, `ACR_OFF_SEL, `ACR_OFF_REF,
                           `ACR_OFF_CORE};
  logic [31:0] rstv[4] = '{`ACR_RST_CLK, `ACR_RST_SEL, `ACR_RST_REF,
                           `ACR_RST_CORE};
  logic [31:0] msk[4] = '{`ACR_WMASK_CLK, `ACR_WMASK_SEL, `ACR_WMASK_REF,
                          `ACR_WMASK_CORE};
  logic [31:0] cv[6] = '{32'h106, 32'h10e, 32'h104, 32'h10c, 32'h105,
                         32'h100};
  logic [31:0] ex[6] = '{32'habf, 32'habf, 32'habc, 32'h2af, 32'habc,
                         32'habf};
  logic [2:0]  cf[6] = '{3'h6, 3'h6, 3'h4, 3'h4, 3'h5, 3'h0};

  acr_top u_dut (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_enable(conv_enable), .conv_channel(conv_channel),
    .raw_data(raw_data), .raw_valid(raw_valid), .adc_clk(adc_clk),
    .conv_ready(conv_ready), .ref_source(ref_source),
    .pad_low_dedicated(pad_low_dedicated), .pad_low_gpio(pad_low_gpio),
    .core_cfg(core_cfg), .result(result), .result_valid(result_valid)
  );
  acr_core_model u_core (
    .clk(clk), .conv_enable(conv_enable), .conv_channel(conv_channel),
    .raw_data(raw_data), .raw_valid(raw_valid)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic hang(input int k);
    if (k >= 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 3000);
    r = bresp;
    bready <= 1'b0;
    hang(k);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 3000);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    hang(k);
  endtask
  function automatic logic pick(input int w);
    return w ? conv_ready : adc_clk;
  endfunction
  // sampled just after an edge, so the pre-edge level is what counts
  task automatic wait_lvl(input int w, input logic l, output int k);
    k = 0;
    while (pick(w) !== l && k < 3000) begin
      @(posedge clk);
      k++;
    end
    hang(k);
  endtask
  task automatic run_len(input int w, input logic l, output int m);
    int k;
    wait_lvl(w, !l, k);
    wait_lvl(w, l, k);
    m = 0;
    while (pick(w) === l && m < 3000) begin
      @(posedge clk);
      m++;
    end
    hang(m);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    error_cnt = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(offs[i]);
      chk(d, rstv[i]);
      wr(offs[i], 32'hffffffff);
      rd(offs[i]);
      chk(d, msk[i]);
    end
    // unmapped place refused
    wr(8'h90, 32'h1);
    chk(r, `ACR_RESP_ERR);
    rd(8'h90);
    chk(d, 32'h0);
    chk(r, `ACR_RESP_ERR);
    // equal phase counts keep the clock at half duty, 25MHz
    wr(`ACR_OFF_CLK, 32'h0505);
    run_len(0, 1'b1, n);
    chk(n, 5);
    run_len(0, 1'b0, n);
    chk(n, 5);
    wr(`ACR_OFF_SEL, 32'h400);
    wr(`ACR_OFF_REF, 32'h20020003);
    wr(`ACR_OFF_CORE, 32'h106);
    u_core.power(1'b1, 4'h0);
    wait_lvl(1, 1'b1, n);
    chk(n >= 18 && n <= 27, 1);
    @(negedge clk);
    chk({ref_source, pad_low_dedicated, pad_low_gpio}, 4'h1);
    // switch to the general-purpose reference
    u_core.power(1'b1, 4'h5);
    run_len(1, 1'b0, n);
    chk(n, 3);
    @(negedge clk);
    chk({ref_source, pad_low_dedicated, pad_low_gpio}, 4'h6);
    rd(`ACR_OFF_REF);
    chk(d, 32'h60020003);
    for (int i = 0; i < 6; i++) begin
      wr(`ACR_OFF_CORE, cv[i]);
      u_core.sample(12'habf);
      @(negedge clk);
      chk(result_valid, 1);
      chk(result, ex[i]);
      chk(core_cfg, cf[i]);
    end
    // channels beyond the table fall back to the pad
    u_core.power(1'b1, 4'hc);
    run_len(1, 1'b0, n);
    chk(n, 3);
    @(negedge clk);
    chk({ref_source, pad_low_dedicated, pad_low_gpio}, 4'h1);
    // zero phase counts run as one system clock
    wr(`ACR_OFF_CLK, 32'h0000);
    run_len(0, 1'b1, n);
    chk(n, 1);
    // second reset restores defaults
    u_core.power(1'b0, 4'h0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`ACR_OFF_CORE);
    chk(d, `ACR_RST_CORE);
    rd(`ACR_OFF_REF);
    chk(d, `ACR_RST_REF);
    tally_and_finish();
  end
endmodule
